// [design/stac_top.sv]
// Converter sequencing, host measurement and six trim channels
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Attenuator before the converter selects divide by three or divide by one.
// - Host may request a measurement any time; request is always accepted.
// - Command steers the mux to the named input; result captured for readout.
// - Divide-by-three results are the raw 10-bit code times three.
// - Result is 12 bits, 8-bit upper and 4-bit lower; LSB is 2 mV.
// - The converter also serves closed-loop trim measurements.
// - Two shared profile-select pins choose one profile for all channels.
// - Active-low enable pin starts closed-loop trimming of loop-mode channels, in profile 0 only.
// - Select 00 gives profile 0, where each channel's mode picks its code.
// - Select 01 applies each channel's stored profile-1 code.
// - Select 11 applies each channel's stored profile-3 code.
// - Each of six channels drives an 8-bit DAC code.
// - Each channel holds four preset codes and two volatile codes.
// - Code goes through a mode selector then the shared profile selector.
// - Host-controlled channels in profile 0 apply the last host-loaded code.
// - Profiles 1, 2, 3 apply the matching preset; 10 selects profile 2.
// - Profile 0 modes: preset code, host-loaded code or closed-loop code.
// - Host-loaded code resets to 80H.
// - Loop update steps the code by polarity and sign; equal leaves it.
module stac_top #(
  parameter int unsigned RATE0_CYC = stac_pkg::RATE0_CYC,
  parameter int unsigned RATE1_CYC = stac_pkg::RATE1_CYC,
  parameter int unsigned RATE2_CYC = stac_pkg::RATE2_CYC,
  parameter int unsigned RATE3_CYC = stac_pkg::RATE3_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] profile_select,
  input wire logic closed_loop_trim_enable_n,
  input wire logic meas_req,
  input wire logic [2:0] meas_sel,
  input wire logic meas_div3,
  output logic meas_busy,
  output logic meas_done,
  output logic [7:0] result_high,
  output logic [3:0] result_low,
  input wire logic [1:0] rate_sel,
  input wire logic loop_div3,
  input wire logic [11:0] mode_cfg,
  input wire logic [191:0] preset_code,
  input wire logic [71:0] setpoint,
  input wire logic [5:0] polarity,
  input wire logic host_we,
  input wire logic [2:0] host_ch,
  input wire logic [7:0] host_data,
  output logic adc_start,
  output logic [2:0] adc_mux_sel,
  output logic adc_div3,
  input wire logic adc_done,
  input wire logic [9:0] adc_code,
  output logic [47:0] dac_code,
  output logic loop_active
);
  logic [1:0] prof_s1_q;
  logic [1:0] prof_q;
  logic clt_s1_q;
  logic clt_n_q;
  logic loop_run;
  logic [19:0] tmr_q;
  logic [19:0] rate_lim;
  logic scan_q;
  logic [2:0] idx_q;
  logic idx_loop;
  logic host_pend_q;
  logic [2:0] host_sel_q;
  logic host_att_q;
  stac_pkg::stac_state_e state_q;
  logic own_host_q;
  logic start_q;
  logic [2:0] mux_q;
  logic att_q;
  logic [9:0] raw_q;
  logic [11:0] scaled;
  logic [11:0] sp_cur;
  logic host_grant;
  logic loop_grant;
  logic skip;
  logic store_loop;
  logic done_q;
  logic [7:0] res_hi_q;
  logic [3:0] res_lo_q;
  logic [5:0] step_vec;
  logic step_up;

  // Pin synchronisers for profile select and loop enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prof_s1_q <= stac_pkg::PROF0;
      prof_q <= stac_pkg::PROF0;
      clt_s1_q <= 1'b1;
      clt_n_q <= 1'b1;
    end else begin
      prof_s1_q <= profile_select;
      prof_q <= prof_s1_q;
      clt_s1_q <= closed_loop_trim_enable_n;
      clt_n_q <= clt_s1_q;
    end
  end

  // Loop runs only with enable low and profile 0
  assign loop_run = !clt_n_q && prof_q == stac_pkg::PROF0;
  assign loop_active = loop_run;

  // Update interval chosen by rate select
  always_comb begin
    case (rate_sel)
      2'h1: rate_lim = RATE1_CYC[19:0];
      2'h2: rate_lim = RATE2_CYC[19:0];
      2'h3: rate_lim = RATE3_CYC[19:0];
      default: rate_lim = RATE0_CYC[19:0];
    endcase
  end

  // Interval timer, cleared to zero while the loop is stopped
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= 20'h00000;
    end else if (!loop_run || tmr_q >= rate_lim - 20'h00001) begin
      tmr_q <= 20'h00000;
    end else begin
      tmr_q <= tmr_q + 20'h00001;
    end
  end

  // Current scanned channel and its setpoint
  assign idx_loop = mode_cfg[idx_q*2 +: 2] == stac_pkg::MODE_LOOP;
  assign sp_cur = setpoint[idx_q*12 +: 12];

  // Arbitration: host first, then the loop scan
  assign host_grant = state_q == stac_pkg::ST_IDLE && host_pend_q;
  assign loop_grant = state_q == stac_pkg::ST_IDLE && !host_pend_q
    && scan_q && loop_run && idx_loop;
  assign skip = state_q == stac_pkg::ST_IDLE && !host_pend_q
    && scan_q && loop_run && !idx_loop;
  assign store_loop = state_q == stac_pkg::ST_STORE && !own_host_q;

  // Scan of all channels once per interval, resumes where it paused
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scan_q <= 1'b0;
      idx_q <= 3'h0;
    end else if (skip || store_loop) begin
      if (idx_q == 3'(stac_pkg::NCH - 1)) begin
        idx_q <= 3'h0;
        scan_q <= 1'b0;
      end else begin
        idx_q <= idx_q + 3'h1;
      end
    end else if (loop_run && tmr_q >= rate_lim - 20'h00001) begin
      scan_q <= 1'b1;
    end
  end

  // Host request latch; a new request wins over the grant
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_pend_q <= 1'b0;
      host_sel_q <= 3'h0;
      host_att_q <= 1'b0;
    end else if (meas_req) begin
      host_pend_q <= 1'b1;
      host_sel_q <= meas_sel;
      host_att_q <= meas_div3;
    end else if (host_grant) begin
      host_pend_q <= 1'b0;
    end
  end

  // Converter sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= stac_pkg::ST_IDLE;
      own_host_q <= 1'b0;
      start_q <= 1'b0;
      mux_q <= 3'h0;
      att_q <= 1'b0;
      raw_q <= 10'h000;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        stac_pkg::ST_IDLE: begin
          if (host_grant) begin
            own_host_q <= 1'b1;
            mux_q <= host_sel_q;
            att_q <= host_att_q;
            start_q <= 1'b1;
            state_q <= stac_pkg::ST_CONV;
          end else if (loop_grant) begin
            own_host_q <= 1'b0;
            mux_q <= idx_q;
            att_q <= loop_div3;
            start_q <= 1'b1;
            state_q <= stac_pkg::ST_CONV;
          end
        end
        stac_pkg::ST_CONV: begin
          if (adc_done && !start_q) begin
            raw_q <= adc_code;
            state_q <= stac_pkg::ST_STORE;
          end
        end
        stac_pkg::ST_STORE: begin
          state_q <= stac_pkg::ST_IDLE;
        end
        default: state_q <= stac_pkg::ST_IDLE;
      endcase
    end
  end

  // Scaling by the attenuation in use
  assign scaled = att_q ? 12'(raw_q) * 12'(stac_pkg::ATT_MUL)
    : {2'h0, raw_q};

  // Host readout registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (state_q == stac_pkg::ST_STORE && own_host_q) begin
        res_hi_q <= scaled[stac_pkg::RES_HI_LSB +: stac_pkg::RES_HI_W];
        res_lo_q <= scaled[stac_pkg::RES_LO_W-1:0];
        done_q <= 1'b1;
      end
    end
  end

  // Loop step: direction from sign and polarity, none when equal
  always_comb begin
    step_vec = 6'h00;
    step_up = (sp_cur > scaled) ^ polarity[idx_q];
    if (store_loop && sp_cur != scaled) begin
      step_vec[idx_q] = 1'b1;
    end
  end

  // Six channels sharing the profile select
  for (genvar c = 0; c < stac_pkg::NCH; c++) begin : g_ch
    stac_trim_channel u_ch (
      .mclk(mclk),
      .arst_n(arst_n),
      .profile(prof_q),
      .mode(mode_cfg[c*2 +: 2]),
      .presets(preset_code[c*32 +: 32]),
      .host_we(host_we && host_ch == 3'(c)),
      .host_data(host_data),
      .trim_step(step_vec[c]),
      .trim_up(step_up),
      .dac_code(dac_code[c*8 +: 8])
    );
  end

  assign adc_start = start_q;
  assign adc_mux_sel = mux_q;
  assign adc_div3 = att_q;
  assign meas_busy = host_pend_q || (state_q != stac_pkg::ST_IDLE
    && own_host_q);
  assign meas_done = done_q;
  assign result_high = res_hi_q;
  assign result_low = res_lo_q;

  accept_req_a: assert property (@(posedge mclk) disable iff (!arst_n)
    meas_req |=> host_pend_q || state_q == stac_pkg::ST_CONV)
    else $error("host request lost");
  mux_steer_a: assert property (@(posedge mclk) disable iff (!arst_n)
    host_grant |=> adc_start && adc_mux_sel == $past(host_sel_q)
    && adc_div3 == $past(host_att_q))
    else $error("mux not steered to host input");
  scale_three_a: assert property (@(posedge mclk) disable iff (!arst_n)
    meas_done && $past(att_q) |-> {result_high, result_low}
    == 12'($past(raw_q)) * 12'h003)
    else $error("divide by three result not scaled");
  result_split_a: assert property (@(posedge mclk) disable iff (!arst_n)
    meas_done && !$past(att_q) |-> {result_high, result_low}
    == {2'h0, $past(raw_q)})
    else $error("unscaled result wrong");
  loop_mux_a: assert property (@(posedge mclk) disable iff (!arst_n)
    loop_grant |=> adc_start && adc_mux_sel == $past(idx_q))
    else $error("loop conversion on wrong input");
  loop_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    adc_start && !own_host_q |-> $past(loop_run))
    else $error("loop conversion while paused");
  no_overlap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    adc_start |=> !adc_start [*2])
    else $error("conversions overlap");
  owner_done_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_q == stac_pkg::ST_STORE && !own_host_q |=> !meas_done)
    else $error("loop result shown to host");
  equal_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    store_loop && sp_cur == scaled |-> step_vec == 6'h00)
    else $error("code stepped at equality");
  cv_host: cover property (@(posedge mclk) disable iff (!arst_n)
    meas_done && $past(att_q));
  cv_loop: cover property (@(posedge mclk) disable iff (!arst_n)
    store_loop && step_vec != 6'h00);
  cv_clash: cover property (@(posedge mclk) disable iff (!arst_n)
    meas_req && state_q == stac_pkg::ST_CONV && !own_host_q);
endmodule
`default_nettype wire

// [design/stac_pkg.sv]
// Shared constants and types for the supply trim and converter controller
package stac_pkg;
  localparam int NCH = 6;
  localparam int CODE_W = 8;
  localparam int RAW_W = 10;
  localparam int RES_W = 12;
  localparam int SEL_W = 3;
  localparam int NPROF = 4;
  localparam int SP_W = RES_W;
  // Result split: upper part and lower part; divide-by-three multiplier
  localparam int RES_HI_W = 8;
  localparam int RES_LO_W = 4;
  localparam int RES_HI_LSB = 4;
  localparam int ATT_MUL = 3;
  // Step of the presented code in millivolts
  localparam int RES_LSB_MV = 2;
  // Code reset values, bipolar zero, and code limits
  localparam logic [7:0] HOST_RST = 8'h80;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_MIN = 8'h00;
  // Profile select encodings
  localparam logic [1:0] PROF0 = 2'h0;
  localparam logic [1:0] PROF1 = 2'h1;
  localparam logic [1:0] PROF2 = 2'h2;
  localparam logic [1:0] PROF3 = 2'h3;
  // Profile-0 source of each channel
  typedef enum logic [1:0] {
    MODE_PRESET = 2'h0,
    MODE_HOST = 2'h1,
    MODE_LOOP = 2'h2
  } stac_mode_e;
  // Converter sequencer states, Gray along idle, convert, store
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_STORE = 2'h3
  } stac_state_e;
  // Closed-loop update intervals
  localparam int CLK_MHZ = 50;
  localparam int RATE0_NS = 432000;
  localparam int RATE1_NS = 1060000;
  localparam int RATE2_NS = 8740000;
  localparam int RATE3_NS = 16900000;
  localparam int RATE0_CYC = RATE0_NS * CLK_MHZ / 1000;
  localparam int RATE1_CYC = RATE1_NS * CLK_MHZ / 1000;
  localparam int RATE2_CYC = RATE2_NS * CLK_MHZ / 1000;
  localparam int RATE3_CYC = RATE3_NS * CLK_MHZ / 1000;
  localparam int TMR_W = 20;
endpackage

// [design/stac_trim_channel.sv]
// One trim channel: code registers, mode and profile selectors, DAC code
`timescale 1ns/1ps
`default_nettype none
module stac_trim_channel (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] profile,
  input wire logic [1:0] mode,
  input wire logic [31:0] presets,
  input wire logic host_we,
  input wire logic [7:0] host_data,
  input wire logic trim_step,
  input wire logic trim_up,
  output logic [7:0] dac_code
);
  logic [7:0] host_q;
  logic [7:0] trim_q;
  logic [7:0] mode_code;
  logic [7:0] dac_d;
  logic [7:0] dac_q;

  // Host-loaded volatile code
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_q <= stac_pkg::HOST_RST;
    end else if (host_we) begin
      host_q <= host_data;
    end
  end

  // Closed-loop code, saturating step
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= stac_pkg::TRIM_RST;
    end else if (trim_step) begin
      if (trim_up && trim_q != stac_pkg::CODE_MAX) begin
        trim_q <= trim_q + 8'h01;
      end else if (!trim_up && trim_q != stac_pkg::CODE_MIN) begin
        trim_q <= trim_q - 8'h01;
      end
    end
  end

  // Mode selector then profile selector
  always_comb begin
    case (mode)
      stac_pkg::MODE_HOST: mode_code = host_q;
      stac_pkg::MODE_LOOP: mode_code = trim_q;
      default: mode_code = presets[7:0];
    endcase
    case (profile)
      stac_pkg::PROF1: dac_d = presets[15:8];
      stac_pkg::PROF2: dac_d = presets[23:16];
      stac_pkg::PROF3: dac_d = presets[31:24];
      default: dac_d = mode_code;
    endcase
  end

  // Registered DAC code
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dac_q <= stac_pkg::HOST_RST;
    end else begin
      dac_q <= dac_d;
    end
  end

  assign dac_code = dac_q;

  prof_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    profile == stac_pkg::PROF1 |=> dac_code == $past(presets[15:8]))
    else $error("profile 1 code not applied");
  prof_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    profile == stac_pkg::PROF3 |=> dac_code == $past(presets[31:24]))
    else $error("profile 3 code not applied");
  host_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    host_we ##1 (profile == stac_pkg::PROF0 && mode == stac_pkg::MODE_HOST)
    |=> dac_code == $past(host_data, 2))
    else $error("host code not applied");
  trim_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !trim_step |=> trim_q == $past(trim_q))
    else $error("trim code moved without update");
endmodule
`default_nettype wire

// [verification/stac_adc_model.sv]
// Converter stand-in: answers each start after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module stac_adc_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic adc_start,
  input wire logic [2:0] adc_mux_sel,
  input wire logic [9:0] base,
  input wire logic [3:0] delay,
  output logic adc_done,
  output logic [9:0] adc_code,
  output logic clash
);
  logic busy_q;
  logic [3:0] cnt_q;
  // One conversion at a time, code depends on the selected input
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      adc_done <= 1'b0;
      adc_code <= 10'h155;
      clash <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      adc_code <= ~adc_code; // Stale code never holds still
      if (adc_start && busy_q) begin
        clash <= 1'b1;
      end
      if (adc_start) begin
        busy_q <= 1'b1;
        cnt_q <= delay;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        adc_done <= 1'b1;
        adc_code <= base + 10'(adc_mux_sel) * 10'h025;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the supply trim and converter controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, arst_n, closed_loop_trim_enable_n, meas_req, meas_div3;
  logic meas_busy, meas_done, loop_div3, host_we, adc_start, adc_div3;
  logic adc_done, loop_active, clash;
  logic [1:0] profile_select, rate_sel;
  logic [2:0] meas_sel, host_ch, adc_mux_sel;
  logic [7:0] result_high, host_data;
  logic [3:0] result_low, adc_delay;
  logic [11:0] mode_cfg;
  logic [191:0] preset_code;
  logic [71:0] setpoint;
  logic [5:0] polarity;
  logic [9:0] adc_code, adc_base;
  logic [47:0] dac_code;
  logic [7:0] host_exp [6];
  int fails, n_checks, k, c;
  logic [1:0] m;

  stac_top #(.RATE0_CYC(40), .RATE1_CYC(50), .RATE2_CYC(60),
    .RATE3_CYC(70)) dut (.mclk(mclk), .arst_n(arst_n),
    .profile_select(profile_select),
    .closed_loop_trim_enable_n(closed_loop_trim_enable_n),
    .meas_req(meas_req), .meas_sel(meas_sel), .meas_div3(meas_div3),
    .meas_busy(meas_busy), .meas_done(meas_done),
    .result_high(result_high), .result_low(result_low),
    .rate_sel(rate_sel), .loop_div3(loop_div3), .mode_cfg(mode_cfg),
    .preset_code(preset_code), .setpoint(setpoint), .polarity(polarity),
    .host_we(host_we), .host_ch(host_ch), .host_data(host_data),
    .adc_start(adc_start), .adc_mux_sel(adc_mux_sel), .adc_div3(adc_div3),
    .adc_done(adc_done), .adc_code(adc_code), .dac_code(dac_code),
    .loop_active(loop_active));

  stac_adc_model adc (.mclk(mclk), .arst_n(arst_n), .adc_start(adc_start),
    .adc_mux_sel(adc_mux_sel), .base(adc_base), .delay(adc_delay),
    .adc_done(adc_done), .adc_code(adc_code), .clash(clash));

  // Clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Expected presented code for an input and attenuation
  function automatic logic [11:0] scaled(input logic [2:0] sel,
                                         input logic d3);
    logic [11:0] r;
    r = {2'h0, 10'(adc_base + 10'(sel) * 10'h025)}; // Converter wraps at 10 bits
    return d3 ? r * 12'h003 : r;
  endfunction

  function automatic logic [7:0] exp_dac(input int ch);
    if (profile_select != 2'h0)
      return preset_code[32 * ch + 8 * profile_select +: 8];
    if (mode_cfg[2 * ch +: 2] == 2'h1) return host_exp[ch];
    return preset_code[32 * ch +: 8];
  endfunction

  task automatic check_dacs();
    tick(5);
    @(negedge mclk);
    for (c = 0; c < 6; c++) begin
      check("dac_code", 16'(dac_code[8 * c +: 8]),
        16'(exp_dac(c)));
    end
    @(posedge mclk);
  endtask

  // Host request, latched fields are then disturbed on purpose
  task automatic measure(input logic [2:0] sel, input logic d3);
    int i;
    adc_delay <= 4'($urandom_range(0, 9));
    meas_req <= 1'b1;
    meas_sel <= sel;
    meas_div3 <= d3;
    @(posedge mclk);
    meas_req <= 1'b0;
    meas_sel <= ~sel;
    meas_div3 <= ~d3;
    @(negedge mclk);
    check("meas_busy", 16'(meas_busy), 16'h0001);
    for (i = 0; i < 300 && meas_done !== 1'b1; i++) @(negedge mclk);
    if (meas_done !== 1'b1) begin
      fails++;
      conclude();
    end
    check("result", {4'h0, result_high, result_low},
      {4'h0, scaled(sel, d3)});
    check("adc_mux_sel", 16'(adc_mux_sel), 16'(sel));
    check("adc_div3", 16'(adc_div3), 16'(d3));
    @(posedge mclk);
  endtask

  // Wait for one loop step on channel 0 and compare the new code
  task automatic wait_step(input logic [7:0] delta);
    int i;
    logic [7:0] v;
    tick(30);
    v = dac_code[7:0];
    for (i = 0; i < 3000 && dac_code[7:0] === v; i++) @(negedge mclk);
    if (dac_code[7:0] === v) begin
      fails++;
      conclude();
    end
    check("trim step", 16'(dac_code[7:0]), {8'h00, 8'(v + delta)});
    @(posedge mclk);
  endtask

  initial begin
    arst_n = 1'b0;
    profile_select = 2'h0;
    closed_loop_trim_enable_n = 1'b1;
    meas_req = 1'b0;
    meas_sel = 3'h0;
    meas_div3 = 1'b0;
    rate_sel = 2'h0;
    loop_div3 = 1'b0;
    mode_cfg = 12'h000;
    preset_code = '0;
    setpoint = '0;
    polarity = 6'h00;
    host_we = 1'b0;
    host_ch = 3'h0;
    host_data = 8'h00;
    adc_base = 10'h000;
    adc_delay = 4'h0;
    fails = 0;
    n_checks = 0;
    for (k = 0; k < 6; k++) host_exp[k] = 8'h80;
    k = $urandom(18881);
    @(negedge mclk);
    check("reset dac", dac_code[15:0], 16'h8080);
    @(posedge mclk);
    arst_n <= 1'b1;
    mode_cfg <= 12'h555;
    check_dacs();
    $display("test reset done");
    // Back-to-back host writes, channel 2 written twice
    for (k = 0; k < 7; k++) begin
      host_we <= 1'b1;
      host_ch <= (k == 6) ? 3'h2 : 3'(k);
      host_data <= 8'($urandom);
      @(posedge mclk);
      host_exp[host_ch] = host_data;
    end
    host_we <= 1'b0;
    check_dacs();
    $display("test host codes done");
    // Every profile with mixed profile-0 sources
    for (k = 0; k < 8; k++) begin
      preset_code <= {6{$urandom}};
      for (c = 0; c < 6; c++) begin
        m = 2'($urandom_range(0, 2));
        mode_cfg[2 * c +: 2] <= (m == 2'h2) ? 2'h3 : m;
      end
      profile_select <= 2'(k);
      check_dacs();
    end
    $display("test profiles done");
    profile_select <= 2'h0;
    mode_cfg <= 12'h000;
    for (k = 0; k < 14; k++) begin
      adc_base <= (k < 2) ? 10'h3FF : 10'($urandom);
      tick(1);
      measure(3'(k % 6), 1'(k / 7));
    end
    $display("test measurement done");
    // Closed loop on channel 0 with host traffic interleaved
    adc_base <= 10'($urandom_range(0, 1000));
    rate_sel <= 2'($urandom);
    loop_div3 <= 1'($urandom);
    mode_cfg <= 12'h002;
    setpoint <= {6{12'hFFF}};
    closed_loop_trim_enable_n <= 1'b0;
    tick(5);
    check("loop_active", 16'(loop_active), 16'h0001);
    wait_step(8'h01);
    measure(3'h4, 1'b1);
    setpoint[11:0] <= scaled(3'h0, loop_div3);
    tick(40);
    k = dac_code[7:0];
    tick(400);
    check("trim equal", 16'(dac_code[7:0]), 16'(k[7:0]));
    setpoint[11:0] <= 12'hFFF;
    polarity <= 6'h01;
    wait_step(8'hFF);
    closed_loop_trim_enable_n <= 1'b1;
    tick(40);
    k = dac_code[7:0];
    tick(400);
    check("paused", 16'(dac_code[7:0]), 16'(k[7:0]));
    check("loop_active", 16'(loop_active), 16'h0000);
    closed_loop_trim_enable_n <= 1'b0;
    profile_select <= 2'h1;
    tick(5);
    check("loop_active", 16'(loop_active), 16'h0000);
    check("no overlap", 16'(clash), 16'h0000);
    $display("test closed loop done");
    conclude();
  end
endmodule
`default_nettype wire
